// ==== core/hpt_map.svh ====
// register offsets, field positions and reset values of the host port control block
// Operation
// - host write taking host-to-cpu bit from 0 to 1 pulses the cpu interrupt.
// - host writes of 1 while that bit is set give no new pulse.
// - cpu write of 1 clears the host-to-cpu bit, re-arming it.
// - writing 0 to either interrupt bit does nothing; reset clears host-to-cpu bit.
// - host may write interrupt fields even while the cpu owns the control register.
// - cpu write of 1 sets cpu-to-host bit and drives host interrupt pin low.
// - host write of 1 clears cpu-to-host bit, pin high; cpu checks 0 first.
// - reset clears cpu-to-host bit, host interrupt pin returns high.
// - exactly one dedicated interrupt output toward the cpu.
// - no events toward system dma controller; internal dma engine needs no setup.
// - suspend ignored when free-run is 1, or free-run and soft-stop both 0.
// - free-run 0, soft-stop 1: dma engine halts after current operations finish.
// - host side keeps working during soft-stop suspend.
// - blocked host data cycle held not ready until suspend ends and fifos serviced.
// - on suspend end dma engine issues drain and refill requests, then resumes.
// - main window decodes identity 0h, emulation 4h, control 30h, addresses 34h, 38h.
// - identity holds type 23-16, class 15-8, revision 7-0; bits 31-24 zero.
// - emulation register: soft-stop bit 1, free-run bit 0; bits 31-2 read zero.
// - control owner has full access; non-owner may only write 1 to interrupt or reset; a non-owner host write of 1 to fetch still pulses fetch_req.
// - cpu-to-host bit is control bit 2, inverse of the host interrupt pin.
// - host-to-cpu bit is control bit 1.
`ifndef HPT_MAP_SVH
`define HPT_MAP_SVH
`define HPT_OFS_IDENT 8'h00
`define HPT_OFS_EMU 8'h04
`define HPT_OFS_CTL 8'h30
`define HPT_OFS_WADDR 8'h34
`define HPT_OFS_RADDR 8'h38
`define HPT_OFS_CFG 8'h30
`define HPT_CTL_HWOB 0
`define HPT_CTL_H2C 1
`define HPT_CTL_C2H 2
`define HPT_CTL_RSV1 3
`define HPT_CTL_FETCH 4
`define HPT_CTL_SRST 7
`define HPT_CTL_HWOBSTAT 8
`define HPT_CTL_DUAL 9
`define HPT_CTL_ASEL 11
`define HPT_EMU_FREE 0
`define HPT_EMU_SOFT 1
`define HPT_CFG_CTL_HOST 0
`define HPT_CFG_ADR_HOST 1
`define HPT_CFG_TMO_LSB 8
`define HPT_CFG_TMO_MSB 15
`define HPT_CFG_RESET 32'h0000_0000
`define HPT_EMU_RESET 2'h0
`define HPT_ADDR_RESET 32'h0000_0000
`endif

// ==== core/hpt_pkg.sv ====
// types of the host port control block
`default_nettype none
package hpt_pkg;
  typedef enum logic [2:0] {
    EMU_RUN,
    EMU_DRAIN,
    EMU_HALT,
    EMU_RESUME
  } hpt_emu_state_t;
  typedef enum logic [1:0] {
    SEL_CONTROL,
    SEL_DATA_INC,
    SEL_ADDRESS,
    SEL_DATA_FIXED
  } hpt_access_t;
endpackage
`default_nettype wire

// ==== core/hpt_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module hpt_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== core/hpt_top.sv ====
// interrupt, emulation suspend and register map of the host port
`timescale 1ns/1ps
`default_nettype none
`include "hpt_map.svh"
module hpt_top #(
  parameter logic [7:0] TYPE_CODE = 8'h5a,  // arbitrary value
  parameter logic [7:0] CLASS_CODE = 8'h3c, // arbitrary value
  parameter logic [7:0] REV_CODE = 8'h07    // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // cpu register bus
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_win,
  input wire logic [7:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  output logic [31:0] cpu_rdata,
  output logic cpu_ack,
  output logic cpu_err,
  // host pins
  input wire logic host_strobe_n,
  input wire logic host_read,
  input wire logic access_select_hi,
  input wire logic access_select_lo,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_ready_n,
  // interrupts
  output logic cpu_irq,
  output logic host_irq_n,
  // emulation and data path
  input wire logic emu_suspend,
  input wire logic dma_idle,
  input wire logic rd_fifo_empty,
  input wire logic wr_fifo_full,
  output logic dma_halt,
  output logic dma_resume,
  output logic fetch_req,
  output logic soft_reset,
  output logic dual_mode,
  output logic hwob,
  output logic [31:0] wr_addr,
  output logic [31:0] rd_addr
);
  // synchronised pins
  logic [36:0] pin_s;
  logic suspend_s, strobe_n_s, read_s;
  // strobe synchronised inverted so the flops' reset value means idle
  logic strobe_s;
  logic [1:0] sel_s;
  logic [31:0] hdata_s;
  logic strobe_n_d;

  hpt_sync #(.WIDTH(37)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({emu_suspend, ~host_strobe_n, host_read, access_select_hi, access_select_lo, host_wdata}),
    .q(pin_s)
  );
  assign {suspend_s, strobe_s, read_s, sel_s, hdata_s} = pin_s;
  assign strobe_n_s = !strobe_s;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobe_n_d <= 1'b1;
    end else begin
      strobe_n_d <= strobe_n_s;
    end
  end

  // host access decode, taken at the falling strobe
  logic host_take, hw_ctl, hr_ctl, hw_addr, hr_addr, data_cycle, blocked;
  assign host_take = strobe_n_d && !strobe_n_s;
  assign hw_ctl = host_take && !read_s && sel_s == hpt_pkg::SEL_CONTROL;
  assign hr_ctl = host_take && read_s && sel_s == hpt_pkg::SEL_CONTROL;
  assign hw_addr = host_take && !read_s && sel_s == hpt_pkg::SEL_ADDRESS;
  assign hr_addr = host_take && read_s && sel_s == hpt_pkg::SEL_ADDRESS;
  assign data_cycle = sel_s[0];
  assign blocked = read_s ? rd_fifo_empty : wr_fifo_full;

  // cpu access decode
  logic cw, cr, c_main, c_cfg, cw_ctl;
  assign cw = cpu_req && cpu_we;
  assign cr = cpu_req && !cpu_we;
  assign c_main = cpu_req && !cpu_win;
  assign c_cfg = cpu_req && cpu_win;
  assign cw_ctl = cw && !cpu_win && cpu_addr == `HPT_OFS_CTL;

  // register storage
  logic [31:0] cfg_reg;
  logic [1:0] emu_reg;
  logic asel_reg, rst_reg;
  logic h2c_reg, c2h_reg;
  logic host_owns, adr_host;
  assign host_owns = cfg_reg[`HPT_CFG_CTL_HOST];
  assign adr_host = cfg_reg[`HPT_CFG_ADR_HOST];

  function automatic logic [31:0] ctl_value(input logic sel, input logic dual, input logic ob,
                                            input logic rst, input logic c2h, input logic h2c);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`HPT_CTL_ASEL] = sel;
    v[`HPT_CTL_DUAL] = dual;
    v[`HPT_CTL_HWOBSTAT] = ob;
    v[`HPT_CTL_SRST] = rst;
    v[`HPT_CTL_RSV1] = 1'b1;
    v[`HPT_CTL_C2H] = c2h;
    v[`HPT_CTL_H2C] = h2c;
    v[`HPT_CTL_HWOB] = ob;
    return v;
  endfunction

  logic [31:0] ctl_rd;
  assign ctl_rd = ctl_value(asel_reg, dual_mode, hwob, rst_reg, c2h_reg, h2c_reg);

  // owner and non-owner writes of the control fields
  logic own_w, cpu_non, host_non;
  logic [31:0] own_d;
  assign own_w = (hw_ctl && host_owns) || (cw_ctl && !host_owns);
  assign own_d = (hw_ctl && host_owns) ? hdata_s : cpu_wdata;
  assign cpu_non = cw_ctl && host_owns && cpu_wdata[`HPT_CTL_SRST];
  assign host_non = hw_ctl && !host_owns && hdata_s[`HPT_CTL_SRST];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asel_reg <= 1'b0;
      dual_mode <= 1'b0;
      hwob <= 1'b0;
      rst_reg <= 1'b0;
      soft_reset <= 1'b0;
    end else begin
      if (own_w) begin
        asel_reg <= own_d[`HPT_CTL_ASEL];
        dual_mode <= own_d[`HPT_CTL_DUAL];
        hwob <= own_d[`HPT_CTL_HWOB];
      end
      if (cpu_non || host_non) begin
        rst_reg <= 1'b1;
        soft_reset <= 1'b1;
      end else if (own_w) begin
        rst_reg <= own_d[`HPT_CTL_SRST];
        soft_reset <= own_d[`HPT_CTL_SRST];
      end
    end
  end

  // interrupt bits; set wins over a clear in the same cycle
  logic h2c_set, h2c_clr, c2h_set, c2h_clr, h2c_next, c2h_next;
  assign h2c_set = hw_ctl && hdata_s[`HPT_CTL_H2C];
  assign h2c_clr = cw_ctl && cpu_wdata[`HPT_CTL_H2C];
  assign c2h_set = cw_ctl && cpu_wdata[`HPT_CTL_C2H];
  assign c2h_clr = hw_ctl && hdata_s[`HPT_CTL_C2H];
  assign h2c_next = h2c_set || (h2c_reg && !h2c_clr);
  assign c2h_next = c2h_set || (c2h_reg && !c2h_clr);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      h2c_reg <= 1'b0;
      c2h_reg <= 1'b0;
      host_irq_n <= 1'b1;
      cpu_irq <= 1'b0;
    end else begin
      h2c_reg <= h2c_next;
      c2h_reg <= c2h_next;
      host_irq_n <= !c2h_next;
      cpu_irq <= h2c_next && !h2c_reg;
    end
  end

  // host fetch request, host only, reads back 0
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fetch_req <= 1'b0;
    end else begin
      fetch_req <= hw_ctl && hdata_s[`HPT_CTL_FETCH];
    end
  end

  // address pointers
  logic cw_wa, cw_ra, hw_wa, hw_ra;
  assign cw_wa = cw && !cpu_win && cpu_addr == `HPT_OFS_WADDR && !adr_host;
  assign cw_ra = cw && !cpu_win && cpu_addr == `HPT_OFS_RADDR && !adr_host;
  assign hw_wa = hw_addr && adr_host && (!dual_mode || !asel_reg);
  assign hw_ra = hw_addr && adr_host && (!dual_mode || asel_reg);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_addr <= `HPT_ADDR_RESET;
      rd_addr <= `HPT_ADDR_RESET;
    end else begin
      if (hw_wa) begin
        wr_addr <= hdata_s;
      end else if (cw_wa) begin
        wr_addr <= cpu_wdata;
      end
      if (hw_ra) begin
        rd_addr <= hdata_s;
      end else if (cw_ra) begin
        rd_addr <= cpu_wdata;
      end
    end
  end

  // configuration and emulation registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_reg <= `HPT_CFG_RESET;
      emu_reg <= `HPT_EMU_RESET;
    end else begin
      if (cw && cpu_win && cpu_addr == `HPT_OFS_CFG) begin
        cfg_reg <= {16'h0000, cpu_wdata[`HPT_CFG_TMO_MSB:`HPT_CFG_TMO_LSB], 6'h00,
                    cpu_wdata[`HPT_CFG_ADR_HOST], cpu_wdata[`HPT_CFG_CTL_HOST]};
      end
      if (cw && !cpu_win && cpu_addr == `HPT_OFS_EMU) begin
        emu_reg <= cpu_wdata[`HPT_EMU_SOFT:`HPT_EMU_FREE];
      end
    end
  end

  // cpu read mux and unmapped detection
  logic [31:0] crd;
  logic cmapped;
  always_comb begin
    crd = 32'h0000_0000;
    cmapped = 1'b1;
    if (c_cfg) begin
      cmapped = cpu_addr == `HPT_OFS_CFG;
      crd = cfg_reg;
    end else begin
      unique case (cpu_addr)
        `HPT_OFS_IDENT: crd = {8'h00, TYPE_CODE, CLASS_CODE, REV_CODE};
        `HPT_OFS_EMU: crd = {30'h0, emu_reg};
        `HPT_OFS_CTL: crd = ctl_rd;
        `HPT_OFS_WADDR: crd = wr_addr;
        `HPT_OFS_RADDR: crd = rd_addr;
        default: cmapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cpu_rdata <= 32'h0000_0000;
      cpu_ack <= 1'b0;
      cpu_err <= 1'b0;
    end else begin
      cpu_ack <= cpu_req;
      cpu_err <= (c_main || c_cfg) && !cmapped;
      cpu_rdata <= (cr && cmapped) ? crd : 32'h0000_0000;
    end
  end

  // host reads and ready; control and address stay reachable in suspend
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      host_rdata <= 32'h0000_0000;
      host_ready_n <= 1'b1;
    end else begin
      if (hr_ctl) begin
        host_rdata <= ctl_rd;
      end else if (hr_addr) begin
        host_rdata <= (dual_mode && !asel_reg) ? wr_addr : rd_addr;
      end
      if (strobe_n_s) begin
        host_ready_n <= 1'b1;
      end else begin
        host_ready_n <= data_cycle && blocked;
      end
    end
  end

  // emulation suspend handling of the internal dma engine
  hpt_pkg::hpt_emu_state_t emu_state, emu_next;
  logic soft_stop;
  assign soft_stop = !emu_reg[`HPT_EMU_FREE] && emu_reg[`HPT_EMU_SOFT];

  always_comb begin
    emu_next = emu_state;
    unique case (emu_state)
      hpt_pkg::EMU_RUN: if (suspend_s && soft_stop) emu_next = hpt_pkg::EMU_DRAIN;
      hpt_pkg::EMU_DRAIN: begin
        if (!suspend_s) begin
          emu_next = hpt_pkg::EMU_RUN;
        end else if (dma_idle) begin
          emu_next = hpt_pkg::EMU_HALT;
        end
      end
      hpt_pkg::EMU_HALT: if (!suspend_s) emu_next = hpt_pkg::EMU_RESUME;
      hpt_pkg::EMU_RESUME: emu_next = hpt_pkg::EMU_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      emu_state <= hpt_pkg::EMU_RUN;
      dma_halt <= 1'b0;
      dma_resume <= 1'b0;
    end else begin
      emu_state <= emu_next;
      dma_halt <= emu_next == hpt_pkg::EMU_DRAIN || emu_next == hpt_pkg::EMU_HALT;
      dma_resume <= emu_next == hpt_pkg::EMU_RESUME;
    end
  end
  // no event outputs toward the system dma controller exist here

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence host_sets_h2c;
    hw_ctl && hdata_s[`HPT_CTL_H2C];
  endsequence
  sequence soft_suspend;
    emu_state == hpt_pkg::EMU_RUN && suspend_s && soft_stop;
  endsequence

  irq_pulse_a: assert property ($rose(h2c_reg) |-> cpu_irq ##1 !cpu_irq)
    else $error("cpu interrupt pulse missing or too long");
  irq_norepeat_a: assert property (h2c_reg && $past(h2c_reg) |-> !cpu_irq)
    else $error("repeat cpu interrupt while bit set");
  cpu_ack_a: assert property (h2c_clr && !h2c_set |=> !h2c_reg)
    else $error("cpu acknowledge did not clear bit");
  zero_write_a: assert property (h2c_reg && !h2c_clr |=> h2c_reg)
    else $error("host-to-cpu bit lost without clear");
  nonowner_irq_a: assert property (host_sets_h2c and !host_owns |=> h2c_reg)
    else $error("host interrupt write refused");
  host_irq_set_a: assert property (c2h_set |=> c2h_reg && !host_irq_n)
    else $error("host interrupt not raised");
  host_irq_clr_a: assert property (c2h_clr && !c2h_set |=> !c2h_reg && host_irq_n)
    else $error("host interrupt not cleared");
  pin_inverse_a: assert property (host_irq_n == !c2h_reg)
    else $error("host interrupt pin not inverse of bit");
  free_run_a: assert property (emu_state == hpt_pkg::EMU_RUN && !soft_stop |=> !dma_halt)
    else $error("dma halted while free");
  soft_halt_a: assert property (soft_suspend |=> dma_halt)
    else $error("dma not halted on soft suspend");
  resume_req_a: assert property (emu_state == hpt_pkg::EMU_HALT && !suspend_s
                                 |=> dma_resume && !dma_halt ##1 !dma_resume)
    else $error("resume request not issued");
  ready_hold_a: assert property (!strobe_n_s && data_cycle && blocked |=> host_ready_n)
    else $error("blocked host cycle not held off");
  ident_read_a: assert property (cr && !cpu_win && cpu_addr == `HPT_OFS_IDENT
                                 |=> cpu_rdata[31:24] == 8'h00 && cpu_ack)
    else $error("identity upper byte not zero");
endmodule
`default_nettype wire

// ==== dv/hpt_host_model.sv ====
// behavioural model of the external host on the host port pins
`timescale 1ns/1ps
`default_nettype none
module hpt_host_model (
  // clock
  input wire logic clk,
  // host pins
  output logic host_strobe_n,
  output logic host_read,
  output logic access_select_hi,
  output logic access_select_lo,
  output logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic host_ready_n
);
  int n_timeout = 0;

  initial begin
    host_strobe_n = 1'b1;
    host_read = 1'b0;
    access_select_hi = 1'b0;
    access_select_lo = 1'b0;
    host_wdata = 32'h0;
  end

  // one host cycle, held until ready is seen low
  task automatic cycle(input logic rd, input logic [1:0] sel, input logic [31:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    host_strobe_n <= 1'b0;
    host_read <= rd;
    {access_select_hi, access_select_lo} <= sel;
    host_wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (host_ready_n !== 1'b0 && n < 400);
    if (n >= 400) n_timeout++;
    q = host_rdata;
    host_strobe_n <= 1'b1;
    // released bus no longer shows the data
    host_wdata <= ~d;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/hpt_top_test.sv ====
// self-checking bench of the host port interrupt and suspend block
`timescale 1ns/1ps
`default_nettype none
`include "hpt_map.svh"
module hpt_top_test;
  // identity codes, arbitrary values
  localparam logic [7:0] TYPE_C = 8'h61;
  localparam logic [7:0] CLASS_C = 8'h2e;
  localparam logic [7:0] REV_C = 8'h13;
  logic clk, nrst, cpu_req, cpu_we, cpu_win, cpu_ack, cpu_err;
  logic [7:0] cpu_addr;
  logic [31:0] cpu_wdata, cpu_rdata, host_wdata, host_rdata, wr_addr, rd_addr, q;
  logic host_strobe_n, host_read, access_select_hi, access_select_lo, host_ready_n;
  logic cpu_irq, host_irq_n, emu_suspend, dma_idle, rd_fifo_empty, wr_fifo_full;
  logic dma_halt, dma_resume, fetch_req, soft_reset, dual_mode, hwob, e, got;
  int n_mismatch = 0;
  int num_checks = 0;
  int irq_cnt = 0;
  int fetch_cnt = 0;

  hpt_top #(.TYPE_CODE(TYPE_C), .CLASS_CODE(CLASS_C), .REV_CODE(REV_C)) i_dut (
    .clk(clk), .nrst(nrst), .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_win(cpu_win),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
    .cpu_err(cpu_err), .host_strobe_n(host_strobe_n), .host_read(host_read),
    .access_select_hi(access_select_hi), .access_select_lo(access_select_lo),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ready_n(host_ready_n),
    .cpu_irq(cpu_irq), .host_irq_n(host_irq_n), .emu_suspend(emu_suspend),
    .dma_idle(dma_idle), .rd_fifo_empty(rd_fifo_empty), .wr_fifo_full(wr_fifo_full),
    .dma_halt(dma_halt), .dma_resume(dma_resume), .fetch_req(fetch_req),
    .soft_reset(soft_reset), .dual_mode(dual_mode), .hwob(hwob), .wr_addr(wr_addr),
    .rd_addr(rd_addr));

  hpt_host_model i_host (
    .clk(clk), .host_strobe_n(host_strobe_n), .host_read(host_read),
    .access_select_hi(access_select_hi), .access_select_lo(access_select_lo),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_ready_n(host_ready_n));

  always #5 clk = ~clk;

  // cycles with the cpu interrupt high
  always @(posedge clk) if (cpu_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  // cycles with the fetch request high
  always @(posedge clk) if (fetch_req === 1'b1) fetch_cnt <= fetch_cnt + 1;

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    num_checks++;
    if (got_v !== exp_v) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // one cpu access, request for one cycle, answer the next
  task automatic cpu(input logic we, input logic win, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_win <= win;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_req <= 1'b0;
    #1;
    q = cpu_rdata;
    e = cpu_err;
    chk(cpu_ack, 1'b1);
  endtask

  task automatic host(input logic rd, input logic [1:0] sel, input logic [31:0] d);
    i_host.cycle(rd, sel, d, q);
    repeat (2) @(posedge clk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    summarize();
  end

  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    cpu_req = 1'b0;
    cpu_we = 1'b0;
    cpu_win = 1'b0;
    cpu_addr = 8'h00;
    cpu_wdata = 32'h0;
    emu_suspend = 1'b0;
    dma_idle = 1'b1;
    rd_fifo_empty = 1'b0;
    wr_fifo_full = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    chk(host_irq_n, 1'b1);
    cpu(1'b1, 1'b0, `HPT_OFS_IDENT, 32'hffff_ffff);
    cpu(1'b0, 1'b0, `HPT_OFS_IDENT, 32'h0);
    chk(q, {8'h00, TYPE_C, CLASS_C, REV_C});
    cpu(1'b1, 1'b0, `HPT_OFS_EMU, 32'hffff_ffff);
    cpu(1'b0, 1'b0, `HPT_OFS_EMU, 32'h0);
    chk(q, 32'h0000_0003);
    cpu(1'b1, 1'b0, `HPT_OFS_WADDR, 32'h0000_1230);
    cpu(1'b1, 1'b0, `HPT_OFS_RADDR, 32'h0000_4560);
    cpu(1'b0, 1'b0, `HPT_OFS_WADDR, 32'h0);
    chk(q, 32'h0000_1230);
    cpu(1'b0, 1'b0, `HPT_OFS_RADDR, 32'h0);
    chk(q, 32'h0000_4560);
    cpu(1'b0, 1'b0, 8'h08, 32'h0);
    chk(e, 1'b1);
    // host raises the cpu interrupt while the cpu owns control
    host(1'b0, 2'b00, 32'h0000_0002);
    chk(irq_cnt, 1);
    cpu(1'b0, 1'b0, `HPT_OFS_CTL, 32'h0);
    chk(q[1], 1'b1);
    host(1'b0, 2'b00, 32'h0000_0002);
    chk(irq_cnt, 1);
    cpu(1'b1, 1'b0, `HPT_OFS_CTL, 32'h0);
    cpu(1'b0, 1'b0, `HPT_OFS_CTL, 32'h0);
    chk(q[1], 1'b1);
    cpu(1'b1, 1'b0, `HPT_OFS_CTL, 32'h0000_0002);
    host(1'b1, 2'b00, 32'h0);
    chk(q[1], 1'b0);
    host(1'b0, 2'b00, 32'h0000_0002);
    chk(irq_cnt, 2);
    // cpu interrupts the host
    cpu(1'b1, 1'b0, `HPT_OFS_CTL, 32'h0000_0004);
    chk(host_irq_n, 1'b0);
    cpu(1'b0, 1'b0, `HPT_OFS_CTL, 32'h0);
    chk(q[2], 1'b1);
    host(1'b0, 2'b00, 32'h0);
    chk(host_irq_n, 1'b0);
    host(1'b0, 2'b00, 32'h0000_0004);
    chk(host_irq_n, 1'b1);
    cpu(1'b0, 1'b0, `HPT_OFS_CTL, 32'h0);
    chk(q[2], 1'b0);
    // ownership of the control register
    host(1'b0, 2'b00, 32'h0000_0001);
    chk(hwob, 1'b0);
    cpu(1'b1, 1'b1, `HPT_OFS_CFG, 32'h0000_0001);
    host(1'b0, 2'b00, 32'h0000_0001);
    chk(hwob, 1'b1);
    cpu(1'b1, 1'b0, `HPT_OFS_CTL, 32'h0);
    chk(hwob, 1'b1);
    // non-owner cpu: soft reset, host interrupt and acknowledge
    cpu(1'b1, 1'b0, `HPT_OFS_CTL, 32'h0000_0086);
    chk(host_irq_n, 1'b0);
    chk(soft_reset, 1'b1);
    host(1'b0, 2'b00, 32'h0000_0203);
    chk(irq_cnt, 3);
    chk(dual_mode, 1'b1);
    chk(soft_reset, 1'b0);
    // hardware reset in mid-run clears both interrupt bits
    @(posedge clk) nrst <= 1'b0;
    @(posedge clk);
    #1;
    chk(host_irq_n, 1'b1);
    @(posedge clk) nrst <= 1'b1;
    repeat (3) @(posedge clk);
    cpu(1'b0, 1'b0, `HPT_OFS_CTL, 32'h0);
    chk(q[2:1], 2'b00);
    // every free-run and soft-stop setting
    for (int m = 0; m < 4; m++) begin
      cpu(1'b1, 1'b0, `HPT_OFS_EMU, 32'(m));
      @(posedge clk) emu_suspend <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk(dma_halt, m == 2);
      @(posedge clk) emu_suspend <= 1'b0;
      got = 1'b0;
      repeat (6) begin
        @(posedge clk);
        #1;
        if (dma_resume === 1'b1) got = 1'b1;
      end
      chk(got, m == 2);
      chk(dma_halt, 1'b0);
    end
    // host keeps working in suspend, blocked data cycle held off
    cpu(1'b1, 1'b0, `HPT_OFS_EMU, 32'h0000_0002);
    @(posedge clk) emu_suspend <= 1'b1;
    host(1'b0, 2'b00, 32'h0000_0010);
    chk(fetch_cnt, 1);
    host(1'b1, 2'b00, 32'h0);
    chk(q, 32'h0000_0008);
    @(posedge clk) wr_fifo_full <= 1'b1;
    fork
      host(1'b0, 2'b01, 32'h0000_0055);
      begin
        repeat (12) @(posedge clk);
        #1;
        chk(host_ready_n, 1'b1);
        chk(dma_halt, 1'b1);
        @(posedge clk);
        emu_suspend <= 1'b0;
        wr_fifo_full <= 1'b0;
      end
    join
    chk(i_host.n_timeout, 0);
    summarize();
  end
endmodule
`default_nettype wire
